// ### sll_params.svh
// register map, field positions and reset values of the lane status block
`ifndef SLL_PARAMS_SVH
`define SLL_PARAMS_SVH

// register indices; byte address is four times the index
`define SLL_LANE3_IDX     12'h4b3
`define SLL_LANE4_IDX     12'h4b4
`define SLL_THR_IDX       12'h4c0
`define SLL_CTRL_IDX      12'h4c1

// lane status byte fields
`define SLL_BIT_DISP      7
`define SLL_BIT_CODE      6
`define SLL_BIT_CTRLCH    5
`define SLL_BIT_DESKEW    4
`define SLL_BIT_ILAS      3
`define SLL_BIT_CKSUM     2
`define SLL_BIT_FRAME     1
`define SLL_BIT_CGS       0

// control register fields
`define SLL_CTRL_SKIP     0
`define SLL_CTRL_CLR      1

// reset values
`define SLL_THR_RST       8'hff
`define SLL_SKIP_RST      1'b0
`define SLL_STATUS_RST    8'h00

`endif

// ### sll_pkg.sv
// types shared by the lane status block
package sll_pkg;
   typedef logic [7:0] sll_byte_type;     // one status or config byte
   typedef logic [31:0] sll_word_type;    // one apb data word
   typedef enum {
      sll_reg_none,
      sll_reg_lane3,
      sll_reg_lane4,
      sll_reg_thr,
      sll_reg_ctrl
   } sll_reg_type;                        // decoded register select
endpackage

// ### sll_err_counter.sv
// saturating per-lane error counter with threshold flag
`timescale 1ns/1ns
module sll_err_counter #(
   parameter int CW = 8                    // counter and threshold width
) (
   input  wire logic          mclk,
   input  wire logic          rst,
   input  wire logic          evt,         // one error seen this cycle
   input  wire logic          clr,         // software counter clear pulse
   input  wire logic [CW-1:0] thr,         // shared error threshold
   output logic      [CW-1:0] cnt_r,       // current error count
   output logic               flag_r       // count at or above threshold
);
   // width check
   if (CW < 1) begin : g_bad_cw
      $error("sll_err_counter: CW must be at least 1");
   end

   logic [CW-1:0] cnt_nxt;                 // next count
   wire           at_max = &cnt_r;         // saturated, stop counting

   // a clear with an event in the same cycle restarts the count at one
   assign cnt_nxt = evt ? (clr ? CW'(1) : (at_max ? cnt_r : cnt_r + CW'(1)))
                        : (clr ? '0 : cnt_r);

   // count register
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // threshold compare, registered
   always_ff @(posedge mclk) begin
      if (rst) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= (cnt_r >= thr);
      end
   end

   // count steps by one on an event
   chk_count_step : assert property (@(posedge mclk) disable iff (rst)
      (evt && !clr && !at_max) |=> (cnt_r == $past(cnt_r) + CW'(1)))
      else $error("error counter did not step");

   // a clear with an event leaves one, not zero
   chk_clear_race : assert property (@(posedge mclk) disable iff (rst)
      (evt && clr) |=> (cnt_r == CW'(1)))
      else $error("event lost at counter clear");
endmodule

// ### sll_link_status.sv
// apb status block for two receive lanes: error flags and sync state
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`include "sll_params.svh"

module sll_link_status #(
   parameter int LANES = 2                  // lane 3 at index 0, lane 4 at 1
) (
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          paddr,
   input  wire sll_pkg::sll_word_type pwdata,
   input  wire logic [3:0]           pstrb,
   output sll_pkg::sll_word_type     prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [LANES-1:0]     disp_err_evt,
   input  wire logic [LANES-1:0]     invalid_code_evt,
   input  wire logic [LANES-1:0]     ctrl_char_evt,
   input  wire logic [LANES-1:0]     lane_deskew_ok,
   input  wire logic [LANES-1:0]     initial_align_sync_ok,
   input  wire logic [LANES-1:0]     config_checksum_ok,
   input  wire logic [LANES-1:0]     frame_sync_ok,
   input  wire logic [LANES-1:0]     code_group_sync_ok,
   output logic                      skip_initial_align_seq
);
   import sll_pkg::*;

   // the map holds exactly two lane registers
   if (LANES != 2) begin : g_bad_lanes
      $error("sll_link_status: LANES must be 2");
   end

   // map an address onto a register select
   function automatic sll_reg_type sll_decode(input logic [31:0] addr);
      sll_reg_type sel;
      sel = sll_reg_none;
      if (addr == {18'h0, `SLL_LANE3_IDX, 2'b00}) sel = sll_reg_lane3;
      if (addr == {18'h0, `SLL_LANE4_IDX, 2'b00}) sel = sll_reg_lane4;
      if (addr == {18'h0, `SLL_THR_IDX, 2'b00})   sel = sll_reg_thr;
      if (addr == {18'h0, `SLL_CTRL_IDX, 2'b00})  sel = sll_reg_ctrl;
      return sel;
   endfunction

   // pack one lane's status byte
   function automatic sll_byte_type sll_pack(input logic [2:0] flags,
                                             input logic [4:0] sync);
      return {flags, sync};
   endfunction

   sll_word_type prdata_r;                  // registered read data
   logic         pready_r;                  // registered ready
   logic         pslverr_r;                 // registered error answer
   sll_byte_type thr_r;                     // shared error threshold
   logic         skip_r;                    // skip alignment sequence mode
   logic         clr_r;                     // counter clear pulse
   logic         pready_nxt;                // ready for this access
   sll_word_type prdata_nxt;                // read data for this access
   logic         pslverr_nxt;               // unmapped address answer

   wire [LANES-1:0] disp_flag;              // per-lane disparity flags
   wire [LANES-1:0] code_flag;              // per-lane invalid code flags
   wire [LANES-1:0] ctrl_flag;              // per-lane control char flags
   wire [7:0]       disp_cnt  [LANES];      // per-lane disparity counts
   wire [7:0]       code_cnt  [LANES];      // per-lane invalid code counts
   wire [7:0]       ctrl_cnt  [LANES];      // per-lane control char counts
   sll_byte_type    lane_byte [LANES];      // assembled status bytes

   // three counters for each lane
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      sll_err_counter #(.CW(8)) u_disp (
         .mclk   (mclk),
         .rst    (rst),
         .evt    (disp_err_evt[i]),
         .clr    (clr_r),
         .thr    (thr_r),
         .cnt_r  (disp_cnt[i]),
         .flag_r (disp_flag[i])
      );
      sll_err_counter #(.CW(8)) u_code (
         .mclk   (mclk),
         .rst    (rst),
         .evt    (invalid_code_evt[i]),
         .clr    (clr_r),
         .thr    (thr_r),
         .cnt_r  (code_cnt[i]),
         .flag_r (code_flag[i])
      );
      sll_err_counter #(.CW(8)) u_ctrl (
         .mclk   (mclk),
         .rst    (rst),
         .evt    (ctrl_char_evt[i]),
         .clr    (clr_r),
         .thr    (thr_r),
         .cnt_r  (ctrl_cnt[i]),
         .flag_r (ctrl_flag[i])
      );
      // status byte, flags on top, sync state below
      assign lane_byte[i] = sll_pack({disp_flag[i], code_flag[i], ctrl_flag[i]},
                                     {lane_deskew_ok[i], initial_align_sync_ok[i],
                                      config_checksum_ok[i], frame_sync_ok[i],
                                      code_group_sync_ok[i]});
   end

   // bus decode
   wire         access   = psel && penable;             // access phase
   sll_reg_type sel;                                    // decoded target
   assign sel        = sll_decode(paddr);
   assign pready_nxt = access && !pready_r;             // one wait state
   wire         wr_take  = access && pready_r && pwrite;   // write lands here
   wire         wr_lane0 = wr_take && pstrb[0];         // low byte enabled

   // read mux and error answer
   always_comb begin
      prdata_nxt  = '0;
      pslverr_nxt = 1'b0;
      unique case (sel)
         sll_reg_lane3: prdata_nxt = {24'h0, lane_byte[0]};
         sll_reg_lane4: prdata_nxt = {24'h0, lane_byte[1]};
         sll_reg_thr:   prdata_nxt = {24'h0, thr_r};
         sll_reg_ctrl:  prdata_nxt = {30'h0, 1'b0, skip_r};
         sll_reg_none:  pslverr_nxt = 1'b1;            // unmapped address
      endcase
   end

   // apb answer registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= '0;
      end else begin
         pready_r  <= pready_nxt;
         pslverr_r <= pready_nxt && pslverr_nxt;
         prdata_r  <= (pready_nxt && !pwrite) ? prdata_nxt : '0;
      end
   end

   // threshold register
   always_ff @(posedge mclk) begin
      if (rst) begin
         thr_r <= `SLL_THR_RST;
      end else if (wr_lane0 && sel == sll_reg_thr) begin
         thr_r <= pwdata[7:0];
      end
   end

   // control register: skip mode level and counter clear pulse
   always_ff @(posedge mclk) begin
      if (rst) begin
         skip_r <= `SLL_SKIP_RST;
         clr_r  <= 1'b0;
      end else begin
         clr_r  <= wr_lane0 && sel == sll_reg_ctrl && pwdata[`SLL_CTRL_CLR];
         if (wr_lane0 && sel == sll_reg_ctrl) begin
            skip_r <= pwdata[`SLL_CTRL_SKIP];
         end
      end
   end

   // outputs straight from flops
   assign prdata                 = prdata_r;
   assign pready                 = pready_r;
   assign pslverr                = pslverr_r;
   assign skip_initial_align_seq = skip_r;

   // disparity flag of lane 4 follows its count
   chk_disp_flag : assert property (@(posedge mclk) disable iff (rst)
      ##1 (disp_flag[1] == $past(disp_cnt[1] >= thr_r)))
      else $error("disparity flag wrong");

   // invalid code flag of lane 3 only rises on a reached threshold
   chk_code_flag : assert property (@(posedge mclk) disable iff (rst)
      $rose(code_flag[0]) |-> $past(code_cnt[0] >= thr_r))
      else $error("invalid code flag rose early");

   // invalid code flag of lane 4 only falls once the count is below threshold
   chk_code_fall : assert property (@(posedge mclk) disable iff (rst)
      $fell(code_flag[1]) |-> $past(code_cnt[1] < thr_r))
      else $error("invalid code flag fell early");

   // control char flag held while count stays at or over threshold
   chk_ctrl_flag : assert property (@(posedge mclk) disable iff (rst)
      (ctrl_cnt[1] >= thr_r) [*2] |-> ctrl_flag[1])
      else $error("control char flag low over threshold");

   // deskew bit of lane 4 read back
   chk_deskew_read : assert property (@(posedge mclk) disable iff (rst)
      (pready_r && !pwrite && !pslverr_r && paddr == {18'h0, `SLL_LANE4_IDX, 2'b00})
      |-> prdata_r[`SLL_BIT_DESKEW] == $past(lane_deskew_ok[1]))
      else $error("deskew bit wrong");

   // alignment sync bit of lane 3 read back
   chk_ilas_read : assert property (@(posedge mclk) disable iff (rst)
      (pready_r && !pwrite && paddr == {18'h0, `SLL_LANE3_IDX, 2'b00})
      |-> prdata_r[`SLL_BIT_ILAS] == $past(initial_align_sync_ok[0]))
      else $error("alignment sync bit wrong");

   // checksum bit of lane 4 read back
   chk_cksum_read : assert property (@(posedge mclk) disable iff (rst)
      (access && !pwrite && !pready_r && sel == sll_reg_lane4)
      |=> prdata_r[`SLL_BIT_CKSUM] == $past(config_checksum_ok[1]))
      else $error("checksum bit wrong");

   // frame sync bit of lane 3 read back
   chk_frame_read : assert property (@(posedge mclk) disable iff (rst)
      (access && !pwrite && !pready_r && sel == sll_reg_lane3)
      |=> pready_r && prdata_r[`SLL_BIT_FRAME] == $past(frame_sync_ok[0]))
      else $error("frame sync bit wrong");

   // code group bit of lane 4 read back
   chk_cgs_read : assert property (@(posedge mclk) disable iff (rst)
      (pready_r && !pwrite && paddr == {18'h0, `SLL_LANE4_IDX, 2'b00})
      |-> prdata_r[`SLL_BIT_CGS] == $past(code_group_sync_ok[1]))
      else $error("code group bit wrong");
endmodule

// ### sll_tx_model.sv
// far-end transmitter model: error pulses and per-lane sync levels
`timescale 1ns/1ns
module sll_tx_model (
   input  wire logic mclk,
   output logic [1:0] disp_err_evt,
   output logic [1:0] invalid_code_evt,
   output logic [1:0] ctrl_char_evt,
   output logic [1:0] lane_deskew_ok,
   output logic [1:0] initial_align_sync_ok,
   output logic [1:0] config_checksum_ok,
   output logic [1:0] frame_sync_ok,
   output logic [1:0] code_group_sync_ok
);
   // link idle, nothing locked
   initial begin
      {disp_err_evt, invalid_code_evt, ctrl_char_evt} = '0;
      {lane_deskew_ok, initial_align_sync_ok, config_checksum_ok} = '0;
      {frame_sync_ok, code_group_sync_ok} = '0;
   end
   // n one-cycle error pulses of one kind, one idle cycle apart
   task automatic burst(input int kind, input int ln, input int n);
      repeat (n) begin
         @(posedge mclk);
         if (kind == 0) disp_err_evt[ln] <= 1'b1;
         else if (kind == 1) invalid_code_evt[ln] <= 1'b1;
         else ctrl_char_evt[ln] <= 1'b1;
         @(posedge mclk);
         {disp_err_evt, invalid_code_evt, ctrl_char_evt} <= '0;
      end
   endtask
   // sync levels of one lane, ordered deskew..code group
   task automatic set_sync(input int ln, input logic [4:0] s);
      @(posedge mclk);
      lane_deskew_ok[ln] <= s[4];
      initial_align_sync_ok[ln] <= s[3];
      config_checksum_ok[ln] <= s[2];
      frame_sync_ok[ln] <= s[1];
      code_group_sync_ok[ln] <= s[0];
   endtask
endmodule

// ### tb_serial_lane_link_status.sv
// self-checking bench for the lane status block
`timescale 1ns/1ns
`include "sll_params.svh"
module tb_serial_lane_link_status;
   import sll_pkg::*;
   localparam logic [31:0] A3 = 32'(`SLL_LANE3_IDX) * 4; // lane 3 status
   localparam logic [31:0] A4 = 32'(`SLL_LANE4_IDX) * 4; // lane 4 status
   localparam logic [31:0] AT = 32'(`SLL_THR_IDX) * 4;   // threshold
   localparam logic [31:0] AC = 32'(`SLL_CTRL_IDX) * 4;  // control
   logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = '0;
   logic [3:0] pstrb = 4'hf;
   sll_word_type pwdata = '0, prdata;
   logic pready, pslverr, skip;
   logic [1:0] de, ie, ce, dk, il, ck, fs, cg;
   int n_mismatch = 0, total_checks = 0, cyc = 0;
   sll_word_type r;
   logic e;
   sll_link_status DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .disp_err_evt(de), .invalid_code_evt(ie),
      .ctrl_char_evt(ce), .lane_deskew_ok(dk), .initial_align_sync_ok(il),
      .config_checksum_ok(ck), .frame_sync_ok(fs), .code_group_sync_ok(cg),
      .skip_initial_align_seq(skip));
   sll_tx_model tx (.mclk(mclk), .disp_err_evt(de), .invalid_code_evt(ie),
      .ctrl_char_evt(ce), .lane_deskew_ok(dk), .initial_align_sync_ok(il),
      .config_checksum_ok(ck), .frame_sync_ok(fs), .code_group_sync_ok(cg));
   // 100 ns clock
   initial forever #50 mclk = ~mclk;
   // hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   // compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   // one apb transfer, waits for pready
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // no timeout of its own: pready or the bench timeout ends this wait
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge mclk);
   endtask
   // read and compare data and error
   task automatic rd(input logic [31:0] a, input logic [31:0] x);
      apb(1'b0, a, '0);
      chk(r, x);
      chk(32'(e), 32'h0);
   endtask
   // reset values and unmapped place
   task automatic t_reset();
      rd(A3, 32'h0); rd(A4, 32'h0); rd(AT, 32'hff); rd(AC, 32'h0);
      apb(1'b0, 32'h1308, '0);
      chk(r, 32'h0);
      chk(32'(e), 32'h1);
      apb(1'b1, 32'h1308, 32'h1);
      chk(32'(e), 32'h1);
      // low byte lane disabled: threshold write ignored
      pstrb <= 4'he;
      apb(1'b1, AT, 32'h5);
      pstrb <= 4'hf;
      rd(AT, 32'hff);
   endtask
   // each sync level bit alone on each lane
   task automatic t_sync();
      for (int ln = 0; ln < 2; ln++) begin
         for (int b = 0; b < 5; b++) begin
            tx.set_sync(ln, 5'(1 << b));
            rd(ln ? A4 : A3, 32'(1 << b));
            rd(ln ? A3 : A4, 32'h0);
         end
         tx.set_sync(ln, 5'h0);
      end
   endtask
   // each error kind: below then at threshold, other lane untouched
   task automatic t_err();
      apb(1'b1, AT, 32'h3);
      for (int k = 0; k < 3; k++) begin
         for (int ln = 0; ln < 2; ln++) begin
            apb(1'b1, AC, 32'h2);
            tx.burst(k, ln, 2);
            repeat (2) @(posedge mclk);
            rd(ln ? A4 : A3, 32'h0);
            tx.burst(k, ln, 1);
            repeat (2) @(posedge mclk);
            rd(ln ? A4 : A3, 32'(8'h80 >> k));
            rd(ln ? A3 : A4, 32'h0);
         end
      end
   endtask
   // skip mode, ignored lane write, zero threshold
   task automatic t_skip();
      apb(1'b1, AC, 32'h1);
      rd(AC, 32'h1);
      chk(32'(skip), 32'h1);
      tx.set_sync(0, 5'h1f);
      rd(A3, 32'h1f);
      chk(r & 32'hffffffe1, 32'h1);
      apb(1'b1, A3, 32'h0);
      chk(32'(e), 32'h0);
      rd(A3, 32'h1f);
      apb(1'b1, AT, 32'h0);
      repeat (2) @(posedge mclk);
      rd(A3, 32'hff);
   endtask
   // counter clear meeting an error pulse in the same cycle, threshold one
   task automatic t_race();
      apb(1'b1, AT, 32'h1);
      fork
         apb(1'b1, AC, 32'h3);
         begin
            repeat (2) @(posedge mclk);
            tx.burst(0, 0, 1);
         end
      join
      repeat (2) @(posedge mclk);
      rd(A3, 32'h9f);
      rd(A4, 32'h0);
   endtask
   // verdict and end of run
   task automatic stop_test();
      $display("mismatches %0d checks %0d", n_mismatch, total_checks);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_sync();
      t_err();
      t_skip();
      t_race();
      stop_test();
   end
endmodule
